// >>> hdl/ffpt_top.sv
// flash protection, program/erase timing and bit-band access controller
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module ffpt_top
  import ffpt_pkg::*;
#(
  parameter int P_PROG_US = T_PROG_US,
  parameter int P_ERASE_US = T_ERASE_US
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // AXI4-Lite register slave
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // instruction fetch port (byte address in flash)
  input wire logic i_if_req,
  input wire logic [14:0] i_if_addr,
  output logic o_if_ack,
  output logic [31:0] o_if_data,
  // data_side_bus read port, shared by core and debugger
  input wire logic i_d_req,
  input wire logic [14:0] i_d_addr,
  output logic o_d_ack,
  output logic o_d_fault,
  output logic [31:0] o_d_data,
  // flash array word port
  output logic [12:0] o_arr_addr,
  output logic o_arr_we,
  output logic [31:0] o_arr_wdata,
  input wire logic [31:0] i_arr_rdata,
  // non-volatile protection store
  input wire logic [15:0] i_nv_pe,
  input wire logic [15:0] i_nv_re,
  output logic o_nv_commit,
  output logic o_nv_sel,
  output logic [15:0] o_nv_data,
  // bit-band alias port
  input wire logic i_bb_req,
  input wire logic [31:0] i_bb_addr,
  input wire logic i_bb_we,
  input wire logic i_bb_wbit,
  output logic o_bb_ack,
  output logic o_bb_fault,
  output logic o_bb_rbit,
  // SRAM word port
  output logic o_sram_en,
  output logic o_sram_we,
  output logic [10:0] o_sram_addr,
  output logic [31:0] o_sram_wmask,
  output logic [31:0] o_sram_wdata,
  input wire logic [31:0] i_sram_rdata,
  // flash controller interrupt
  output logic o_irq
);
  typedef struct packed {
    ffpt_state_e st;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] fa;
    logic [31:0] fd;
    logic [3:0] ctl;
    logic [1:0] ris;
    logic [1:0] imask;
    logic [BLOCKS-1:0] pe;
    logic [BLOCKS-1:0] re;
    logic [7:0] usec;
    logic [15:0] cnt;
    logic [12:0] widx;
    logic rd_src;
    logic [12:0] arr_addr;
    logic arr_we;
    logic [31:0] arr_wdata;
    logic if_ack;
    logic [31:0] if_data;
    logic d_ack;
    logic d_fault;
    logic [31:0] d_data;
    logic nv_commit;
    logic nv_sel;
    logic [15:0] nv_data;
    logic [1:0] bb_ph;
    logic [4:0] bb_bit;
    logic bb_ack;
    logic bb_fault;
    logic bb_rbit;
    logic sram_en;
    logic sram_we;
    logic [10:0] sram_addr;
    logic [31:0] sram_wmask;
    logic [31:0] sram_wdata;
    logic irq;
  } ffpt_top_s;
  ffpt_top_s s, next_s;

  logic tick;
  logic bb_hit;
  logic [10:0] bb_word;
  logic [4:0] bb_bit;
  logic ev_acc;
  logic ev_done;
  logic [31:0] wv;
  logic [32:0] rd;

  ffpt_usec_tick u_tick (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_reload(s.usec),
    .o_tick(tick)
  );

  ffpt_bitband u_bb (
    .i_addr(i_bb_addr),
    .o_hit(bb_hit),
    .o_word(bb_word),
    .o_bit(bb_bit)
  );

  // register read view: {mapped, data}
  function automatic logic [32:0] reg_rd(input ffpt_top_s x, input logic [7:0] a);
    unique case (a)
      A_ADDR: reg_rd = {1'b1, x.fa};
      A_DATA: reg_rd = {1'b1, x.fd};
      A_CTL: reg_rd = {1'b1, 28'h0000000, x.ctl};
      A_RIS: reg_rd = {1'b1, 30'h00000000, x.ris};
      A_MASK: reg_rd = {1'b1, 30'h00000000, x.imask};
      A_MISC: reg_rd = {1'b1, 30'h00000000, x.ris & x.imask};
      A_PE: reg_rd = {1'b1, 16'h0000, x.pe};
      A_RE: reg_rd = {1'b1, 16'h0000, x.re};
      A_USEC: reg_rd = {1'b1, 24'h000000, x.usec};
      default: reg_rd = {1'b0, 32'h00000000};
    endcase
  endfunction

  // protection block of a flash byte address
  function automatic logic [3:0] blk(input logic [14:0] a);
    blk = a[14:11];
  endfunction

  always_comb begin
    next_s = s;
    ev_acc = 1'b0;
    ev_done = 1'b0;
    next_s.if_ack = 1'b0;
    next_s.d_ack = 1'b0;
    next_s.d_fault = 1'b0;
    next_s.nv_commit = 1'b0;
    next_s.arr_we = 1'b0;
    next_s.bb_ack = 1'b0;
    next_s.bb_fault = 1'b0;
    next_s.sram_en = 1'b0;
    next_s.sram_we = 1'b0;
    // write address and data may arrive in either order
    if (i_awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.awaddr = i_awaddr[7:0];
    end
    if (i_wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.wdata = i_wdata;
      next_s.wstrb = i_wstrb;
    end
    if (i_bready && s.bvalid) begin
      next_s.bvalid = 1'b0;
    end
    rd = reg_rd(s, s.awaddr);
    for (int i = 0; i < 4; i++) begin
      wv[i*8 +: 8] = s.wstrb[i] ? s.wdata[i*8 +: 8] : rd[i*8 +: 8];
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = rd[32] ? RESP_OK : RESP_ERR;
      unique case (s.awaddr)
        A_ADDR: next_s.fa = wv;
        A_DATA: next_s.fd = wv;
        A_CTL: begin
          // keyless writes and writes during an operation are dropped
          if (wv[31:16] == FC_KEY && s.ctl == 4'h0 && s.st == ST_IDLE) begin
            next_s.ctl = wv[3:0];
          end
        end
        A_MASK: next_s.imask = wv[1:0];
        A_MISC: next_s.ris = s.ris & ~wv[1:0];
        A_PE: next_s.pe = s.pe & wv[BLOCKS-1:0];
        A_RE: next_s.re = s.re & wv[BLOCKS-1:0];
        A_USEC: next_s.usec = wv[7:0];
        default: ;
      endcase
    end
    if (i_rready && s.rvalid) begin
      next_s.rvalid = 1'b0;
    end
    if (i_arvalid && s.arready) begin
      rd = reg_rd(s, i_araddr[7:0]);
      next_s.rvalid = 1'b1;
      next_s.rdata = rd[31:0];
      next_s.rresp = rd[32] ? RESP_OK : RESP_ERR;
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    unique case (s.st)
      ST_LOAD: begin
        // stored image replaces any uncommitted clears
        next_s.pe = i_nv_pe;
        next_s.re = i_nv_re;
        next_s.st = ST_IDLE;
      end
      ST_IDLE: begin
        if (s.ctl[FC_COMMIT]) begin
          next_s.nv_commit = 1'b1;
          next_s.nv_sel = s.fa[0];
          next_s.nv_data = s.fa[0] ? s.pe : s.re;
          next_s.ctl = 4'h0;
        end else if (s.ctl[FC_WRITE] || s.ctl[FC_ERASE]) begin
          if (!s.pe[blk(s.fa[14:0])]) begin
            next_s.ctl = 4'h0;
            ev_acc = 1'b1;
          end else begin
            next_s.cnt = s.ctl[FC_WRITE] ? 16'(P_PROG_US) : 16'(P_ERASE_US);
            next_s.st = ST_WAIT;
          end
        end else if (s.ctl[FC_MERASE]) begin
          // mass erase needs every block open
          if (!(&s.pe)) begin
            next_s.ctl = 4'h0;
            ev_acc = 1'b1;
          end else begin
            next_s.cnt = 16'(P_ERASE_US);
            next_s.st = ST_WAIT;
          end
        end else if (i_if_req && !s.if_ack) begin
          next_s.arr_addr = i_if_addr[14:2];
          next_s.rd_src = 1'b0;
          next_s.st = ST_RD;
        end else if (i_d_req && !s.d_ack) begin
          if (!s.re[blk(i_d_addr)]) begin
            next_s.d_ack = 1'b1;
            next_s.d_fault = 1'b1;
            next_s.d_data = 32'h00000000;
          end else begin
            next_s.arr_addr = i_d_addr[14:2];
            next_s.rd_src = 1'b1;
            next_s.st = ST_RD;
          end
        end
      end
      ST_RD: begin
        if (s.rd_src) begin
          next_s.d_ack = 1'b1;
          next_s.d_data = i_arr_rdata;
        end else begin
          next_s.if_ack = 1'b1;
          next_s.if_data = i_arr_rdata;
        end
        next_s.st = ST_IDLE;
      end
      ST_WAIT: begin
        // reads are not accepted here, so fetches stall
        if (s.cnt == 16'h0000) begin
          if (s.ctl[FC_WRITE]) begin
            next_s.arr_addr = s.fa[14:2];
            next_s.st = ST_PRD;
          end else if (s.ctl[FC_ERASE]) begin
            next_s.arr_addr = {s.fa[14:10], 8'h00};
            next_s.widx = PAGE_LAST;
            next_s.st = ST_EWR;
          end else begin
            next_s.arr_addr = 13'h0000;
            next_s.widx = ARRAY_LAST;
            next_s.st = ST_EWR;
          end
        end else if (tick) begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      ST_PRD: begin
        next_s.arr_we = 1'b1;
        next_s.arr_wdata = i_arr_rdata & s.fd;
        next_s.ctl = 4'h0;
        ev_done = 1'b1;
        next_s.st = ST_IDLE;
      end
      ST_EWR: begin
        next_s.arr_we = 1'b1;
        next_s.arr_wdata = ERASED;
        if (s.arr_we) begin
          next_s.arr_addr = s.arr_addr + 13'h0001;
          next_s.widx = s.widx - 13'h0001;
          if (s.widx == 13'h0000) begin
            next_s.arr_we = 1'b0;
            next_s.arr_addr = s.arr_addr;
            next_s.ctl = 4'h0;
            ev_done = 1'b1;
            next_s.st = ST_IDLE;
          end
        end
      end
    endcase

    // hardware events win over a same-cycle software clear
    if (ev_acc) begin
      next_s.ris[IS_ACC] = 1'b1;
    end
    if (ev_done) begin
      next_s.ris[IS_PROG] = 1'b1;
    end
    next_s.irq = |(next_s.ris & next_s.imask);

    // bit-band: one masked SRAM access per alias access inside the span; a miss faults without one
    unique case (s.bb_ph)
      2'h0: begin
        if (i_bb_req && !s.bb_ack) begin
          if (!bb_hit) begin
            next_s.bb_ack = 1'b1;
            next_s.bb_fault = 1'b1;
          end else begin
            next_s.sram_en = 1'b1;
            next_s.sram_we = i_bb_we;
            next_s.sram_addr = bb_word;
            next_s.sram_wmask = 32'h00000001 << bb_bit;
            next_s.sram_wdata = {32{i_bb_wbit}};
            next_s.bb_bit = bb_bit;
            if (i_bb_we) begin
              next_s.bb_ack = 1'b1;
            end else begin
              next_s.bb_ph = 2'h1;
            end
          end
        end
      end
      2'h1: next_s.bb_ph = 2'h2;
      2'h2: begin
        next_s.bb_rbit = i_sram_rdata[s.bb_bit];
        next_s.bb_ack = 1'b1;
        next_s.bb_ph = 2'h0;
      end
      default: next_s.bb_ph = 2'h0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s <= '0;
      s.st <= ST_LOAD;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.pe <= '1;
      s.re <= '1;
      s.usec <= USEC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign o_awready = s.awready;
  assign o_wready = s.wready;
  assign o_bresp = s.bresp;
  assign o_bvalid = s.bvalid;
  assign o_arready = s.arready;
  assign o_rdata = s.rdata;
  assign o_rresp = s.rresp;
  assign o_rvalid = s.rvalid;
  assign o_if_ack = s.if_ack;
  assign o_if_data = s.if_data;
  assign o_d_ack = s.d_ack;
  assign o_d_fault = s.d_fault;
  assign o_d_data = s.d_data;
  assign o_arr_addr = s.arr_addr;
  assign o_arr_we = s.arr_we;
  assign o_arr_wdata = s.arr_wdata;
  assign o_nv_commit = s.nv_commit;
  assign o_nv_sel = s.nv_sel;
  assign o_nv_data = s.nv_data;
  assign o_bb_ack = s.bb_ack;
  assign o_bb_fault = s.bb_fault;
  assign o_bb_rbit = s.bb_rbit;
  assign o_sram_en = s.sram_en;
  assign o_sram_we = s.sram_we;
  assign o_sram_addr = s.sram_addr;
  assign o_sram_wmask = s.sram_wmask;
  assign o_sram_wdata = s.sram_wdata;
  assign o_irq = s.irq;
endmodule // ffpt_top

// >>> hdl/ffpt_pkg.sv
// constants, register map and state types for the flash protection and timing block
package ffpt_pkg;
  // clock and microsecond timing
  localparam int CLK_MHZ = 125;
  localparam logic [7:0] USEC_RESET = 8'(CLK_MHZ - 1);
  localparam int T_PROG_US = 20;
  localparam int T_ERASE_US = 12000;
  // register byte offsets
  localparam logic [7:0] A_ADDR = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_CTL = 8'h08;
  localparam logic [7:0] A_RIS = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_MISC = 8'h14;
  localparam logic [7:0] A_PE = 8'h18;
  localparam logic [7:0] A_RE = 8'h1C;
  localparam logic [7:0] A_USEC = 8'h20;
  // control register fields
  localparam logic [15:0] FC_KEY = 16'hA442;
  localparam int FC_WRITE = 0;
  localparam int FC_ERASE = 1;
  localparam int FC_MERASE = 2;
  localparam int FC_COMMIT = 3;
  // interrupt status bits
  localparam int IS_ACC = 0;
  localparam int IS_PROG = 1;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // flash geometry
  localparam int BLOCKS = 16;
  localparam logic [12:0] PAGE_LAST = 13'h00FF;
  localparam logic [12:0] ARRAY_LAST = 13'h1FFF;
  localparam logic [31:0] ERASED = 32'hFFFF_FFFF;
  // SRAM and bit-band alias
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] BB_BASE = 32'h2200_0000;
  localparam logic [31:0] BB_SPAN = 32'h0004_0000;
  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_RD, ST_WAIT, ST_PRD, ST_EWR} ffpt_state_e;
endpackage

// >>> hdl/ffpt_usec_tick.sv
// one-microsecond enable pulse divided down from the system clock
`timescale 1ns/1ps
module ffpt_usec_tick
  import ffpt_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // setting and pulse
  input wire logic [7:0] i_reload,
  output logic o_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } ffpt_tick_s;
  ffpt_tick_s s, next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == 8'h00) begin
      next_s.cnt = i_reload;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt - 8'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s <= '{cnt: USEC_RESET, tick: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;
endmodule // ffpt_usec_tick

// >>> hdl/ffpt_bitband.sv
// bit-band alias address to SRAM word and bit translation
`timescale 1ns/1ps
module ffpt_bitband
  import ffpt_pkg::*;
(
  // alias address in
  input wire logic [31:0] i_addr,
  // translated location
  output logic o_hit,
  output logic [10:0] o_word,
  output logic [4:0] o_bit
);
  logic [31:0] off;
  logic [12:0] byte_off;

  always_comb begin
    off = i_addr - BB_BASE;
    // alias = base + byte*32 + bit*4
    byte_off = off[17:5];
    o_hit = (i_addr >= BB_BASE) && (off < BB_SPAN);
    o_word = byte_off[12:2];
    o_bit = {byte_off[1:0], off[4:2]};
  end
endmodule // ffpt_bitband

// >>> tb/ffpt_mem_model.sv
// flash array, sram and protection store facing the controller
`timescale 1ns/1ps
module ffpt_mem_model
  import ffpt_pkg::*;
(
  // clock
  input wire logic i_clock,
  // flash array
  input wire logic [12:0] i_arr_addr,
  input wire logic i_arr_we,
  input wire logic [31:0] i_arr_wdata,
  output logic [31:0] o_arr_rdata,
  // protection store
  input wire logic i_commit,
  input wire logic i_sel,
  input wire logic [15:0] i_data,
  output logic [15:0] o_nv_pe,
  output logic [15:0] o_nv_re,
  // sram word port
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [10:0] i_addr,
  input wire logic [31:0] i_wmask,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  logic [31:0] flash [0:8191];
  logic [31:0] sram [0:2047];
  initial begin
    for (int i = 0; i < 8192; i++) flash[i] = ERASED;
    for (int i = 0; i < 2048; i++) sram[i] = 32'h0;
    o_nv_pe = 16'hFFFF;
    o_nv_re = 16'hFFFF;
  end
  assign o_arr_rdata = flash[i_arr_addr];
  // the store ignores reset, so only a commit changes what comes back after one
  always @(posedge i_clock) begin
    if (i_arr_we) flash[i_arr_addr] <= i_arr_wdata;
    if (i_commit && i_sel) o_nv_pe <= i_data;
    if (i_commit && !i_sel) o_nv_re <= i_data;
    if (i_en && i_we) sram[i_addr] <= (sram[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
    if (i_en) o_rdata <= sram[i_addr];
  end
endmodule // ffpt_mem_model

// >>> tb/ffpt_chk.sv
// assertions on the flash protection top ports
`timescale 1ns/1ps
module ffpt_chk
  import ffpt_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // reads
  input wire logic o_if_ack,
  input wire logic [14:0] i_d_addr,
  input wire logic o_d_ack,
  input wire logic o_d_fault,
  input wire logic [31:0] o_d_data,
  // flash array and store
  input wire logic [12:0] o_arr_addr,
  input wire logic o_arr_we,
  input wire logic [31:0] o_arr_wdata,
  input wire logic [31:0] i_arr_rdata,
  input wire logic [15:0] i_nv_pe,
  input wire logic [15:0] i_nv_re,
  input wire logic o_nv_commit,
  input wire logic o_nv_sel,
  input wire logic [15:0] o_nv_data,
  // bit-band and sram
  input wire logic i_bb_req,
  input wire logic [31:0] i_bb_addr,
  input wire logic o_bb_ack,
  input wire logic o_bb_fault,
  input wire logic o_sram_en,
  input wire logic o_sram_we,
  input wire logic [10:0] o_sram_addr,
  input wire logic [31:0] o_sram_wmask
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic bb_in;
  assign bb_in = (i_bb_addr >= BB_BASE) && (i_bb_addr < BB_BASE + BB_SPAN);
  AST_FAULT_ZERO: assert property (
    o_d_fault |-> o_d_ack && o_d_data == 32'h0) else $error("data fault not clean");
  AST_DATA_READ: assert property (
    o_d_ack && !o_d_fault |-> o_d_data == $past(i_arr_rdata)
      && $past(o_arr_addr) == i_d_addr[14:2]) else $error("data read wrong word");
  AST_STALL: assert property (
    o_arr_we |-> !o_if_ack && !o_d_ack) else $error("read answered during write");
  AST_ARR_WRITE: assert property (
    o_arr_we |-> o_arr_wdata == ERASED || (o_arr_wdata & ~i_arr_rdata) == 32'h0)
    else $error("array write sets a zero bit");
  AST_BB_FAULT: assert property (
    o_bb_ack && i_bb_req |-> o_bb_fault == !bb_in) else $error("alias fault wrong");
  AST_BB_WORD: assert property (
    o_sram_en && i_bb_req |-> o_sram_addr == i_bb_addr[17:7]) else $error("alias word wrong");
  AST_BB_MASK: assert property (
    o_sram_en && o_sram_we |-> o_sram_wmask == 32'h1 << i_bb_addr[6:2])
    else $error("alias bit mask wrong");
  AST_NV_CLEAR: assert property (
    o_nv_commit |-> (o_nv_data & ~(o_nv_sel ? i_nv_pe : i_nv_re)) == 16'h0)
    else $error("commit sets a cleared bit");
endmodule // ffpt_chk

bind ffpt_top ffpt_chk u_chk (
  .i_clock, .i_rst, .o_if_ack, .i_d_addr, .o_d_ack, .o_d_fault, .o_d_data, .o_arr_addr,
  .o_arr_we, .o_arr_wdata, .i_arr_rdata, .i_nv_pe, .i_nv_re, .o_nv_commit, .o_nv_sel,
  .o_nv_data, .i_bb_req, .i_bb_addr, .o_bb_ack, .o_bb_fault, .o_sram_en, .o_sram_we,
  .o_sram_addr, .o_sram_wmask);

// >>> tb/tb_top.sv
// self-checking bench for the flash protection top
`timescale 1ns/1ps
module tb_top
  import ffpt_pkg::*;
;
  localparam int LIM = 10000;
  logic i_clock, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic i_if_req, i_d_req, i_bb_req, i_bb_we, i_bb_wbit;
  logic [31:0] i_awaddr, i_wdata, i_araddr, i_bb_addr, i_arr_rdata, i_sram_rdata;
  logic [3:0] i_wstrb;
  logic [14:0] i_if_addr, i_d_addr;
  logic [15:0] i_nv_pe, i_nv_re, o_nv_data;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_if_ack, o_d_ack, o_d_fault;
  logic o_arr_we, o_nv_commit, o_nv_sel, o_bb_ack, o_bb_fault, o_bb_rbit, o_sram_en;
  logic o_sram_we, o_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, o_if_data, o_d_data, o_arr_wdata, o_sram_wmask, o_sram_wdata;
  logic [12:0] o_arr_addr;
  logic [10:0] o_sram_addr;
  int fails, tests_run;
  // short program and erase counts keep the run brief
  ffpt_top #(.P_PROG_US(1), .P_ERASE_US(1)) dut (
    .i_clock, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_if_req, .i_if_addr, .o_if_ack, .o_if_data, .i_d_req,
    .i_d_addr, .o_d_ack, .o_d_fault, .o_d_data, .o_arr_addr, .o_arr_we, .o_arr_wdata,
    .i_arr_rdata, .i_nv_pe, .i_nv_re, .o_nv_commit, .o_nv_sel, .o_nv_data, .i_bb_req,
    .i_bb_addr, .i_bb_we, .i_bb_wbit, .o_bb_ack, .o_bb_fault, .o_bb_rbit, .o_sram_en,
    .o_sram_we, .o_sram_addr, .o_sram_wmask, .o_sram_wdata, .i_sram_rdata, .o_irq);
  ffpt_mem_model mem (.i_clock, .i_arr_addr(o_arr_addr), .i_arr_we(o_arr_we),
    .i_arr_wdata(o_arr_wdata), .o_arr_rdata(i_arr_rdata), .i_commit(o_nv_commit),
    .i_sel(o_nv_sel), .i_data(o_nv_data), .o_nv_pe(i_nv_pe), .o_nv_re(i_nv_re),
    .i_en(o_sram_en), .i_we(o_sram_we), .i_addr(o_sram_addr), .i_wmask(o_sram_wmask),
    .i_wdata(o_sram_wdata), .o_rdata(i_sram_rdata));
  initial begin
    i_clock = 1'h0;
    forever #4 i_clock = ~i_clock;
  end
  task automatic stop_test;
    $display("tests %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic to(input int n);
    if (n >= LIM) begin
      fails++;
      $display("unexpected %0t wait ran out", $time);
      stop_test;
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic axi_wre(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clock);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {24'h0, a, d, 3'h7};
    do begin
      @(posedge i_clock);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'h0;
      if (i_wvalid && o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid && n < LIM);
    chk({30'h0, o_bresp}, {30'h0, er});
    i_bready <= 1'h0;
    to(n);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    axi_wre(a, d, RESP_OK);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_clock);
    {i_araddr, i_arvalid, i_rready} <= {24'h0, a, 2'h3};
    do begin
      @(posedge i_clock);
      n++;
      if (i_arvalid && o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid && n < LIM);
    chk(o_rdata & m, e);
    chk({30'h0, o_rresp}, {30'h0, er});
    i_rready <= 1'h0;
    to(n);
  endtask
  task automatic op(input logic [14:0] a, input logic [31:0] d, input logic [15:0] c);
    axi_wr(A_DATA, d);
    axi_wr(A_ADDR, {17'h0, a});
    axi_wr(A_CTL, {FC_KEY, c});
  endtask
  task automatic mrd(input logic f, input logic [14:0] a, input logic [31:0] e,
      input logic ef);
    int n;
    n = 0;
    @(posedge i_clock);
    {i_if_addr, i_d_addr, i_if_req, i_d_req} <= {a, a, f, !f};
    do begin
      @(posedge i_clock);
      n++;
    end while (!(f ? o_if_ack : o_d_ack) && n < LIM);
    chk(f ? o_if_data : o_d_data, e);
    chk({31'h0, !f && o_d_fault}, {31'h0, ef});
    {i_if_req, i_d_req} <= 2'h0;
    // idle gap so a late answer cannot be taken for the next one
    repeat (3) @(posedge i_clock);
    to(n);
  endtask
  task automatic bbc(input logic we, input logic [31:0] a, input logic b, input logic ef);
    int n;
    n = 0;
    @(posedge i_clock);
    {i_bb_we, i_bb_addr, i_bb_wbit, i_bb_req} <= {we, a, b, 1'h1};
    do begin
      @(posedge i_clock);
      n++;
    end while (!o_bb_ack && n < LIM);
    if (!we) chk({31'h0, o_bb_rbit}, {31'h0, b});
    chk({31'h0, o_bb_fault}, {31'h0, ef});
    i_bb_req <= 1'h0;
    repeat (3) @(posedge i_clock);
    to(n);
  endtask
  task automatic t_regs;
    rdc(A_PE, 32'hFFFF, 32'hFFFF, RESP_OK);
    rdc(A_RE, 32'hFFFF, 32'hFFFF, RESP_OK);
    rdc(A_USEC, 32'hFF, {24'h0, USEC_RESET}, RESP_OK);
    rdc(8'h40, 32'hFFFF_FFFF, 32'h0, RESP_ERR);
    axi_wre(8'h40, 32'h0, RESP_ERR);
    axi_wr(A_USEC, 32'h1);
    rdc(A_USEC, 32'hFF, 32'h1, RESP_OK);
    // lane 0 masked off: the setting must keep its value
    i_wstrb <= 4'hE;
    axi_wr(A_USEC, 32'h0);
    i_wstrb <= 4'hF;
    rdc(A_USEC, 32'hFF, 32'h1, RESP_OK);
    $display("test regs done");
  endtask
  task automatic t_prog;
    op(15'h0804, 32'hA5A5_0F0F, 16'h0001);
    mrd(1'h0, 15'h0804, 32'hA5A5_0F0F, 1'h0);
    op(15'h0804, 32'hFFFF_00FF, 16'h0001);
    mrd(1'h0, 15'h0804, 32'hA5A5_000F, 1'h0);
    rdc(A_RIS, 32'h1 << IS_PROG, 32'h1 << IS_PROG, RESP_OK);
    axi_wr(A_MISC, 32'h1 << IS_PROG);
    rdc(A_RIS, 32'h3, 32'h0, RESP_OK);
    op(15'h0C00, 32'h0, 16'h0001);
    mrd(1'h0, 15'h0C00, 32'h0, 1'h0);
    op(15'h0800, 32'h0, 16'h0002);
    mrd(1'h0, 15'h0804, ERASED, 1'h0);
    mrd(1'h1, 15'h0BFC, ERASED, 1'h0);
    mrd(1'h0, 15'h0C00, 32'h0, 1'h0);
    // mass erase with every block open, then restore the word later tests rely on
    op(15'h0000, 32'h0, 16'h0004);
    mrd(1'h1, 15'h0C00, ERASED, 1'h0);
    op(15'h0C00, 32'h0, 16'h0001);
    $display("test program erase done");
  endtask
  task automatic t_protect;
    axi_wr(A_PE, 32'hFFFF_FFFD);
    axi_wr(A_MASK, 32'h1 << IS_ACC);
    op(15'h0C00, 32'h0, 16'h0002);
    mrd(1'h0, 15'h0C00, 32'h0, 1'h0);
    rdc(A_RIS, 32'h1 << IS_ACC, 32'h1 << IS_ACC, RESP_OK);
    chk({31'h0, o_irq}, 32'h1);
    axi_wr(A_MISC, 32'h1 << IS_ACC);
    rdc(A_MISC, 32'h3, 32'h0, RESP_OK);
    chk({31'h0, o_irq}, 32'h0);
    axi_wr(A_PE, 32'hFFFF_FFFF);
    rdc(A_PE, 32'hFFFF, 32'hFFFD, RESP_OK);
    axi_wr(A_RE, 32'hFFFF_FFFB);
    mrd(1'h0, 15'h1000, 32'h0, 1'h1);
    op(15'h1000, 32'h1234_5678, 16'h0001);
    mrd(1'h1, 15'h1000, 32'h1234_5678, 1'h0);
    axi_wr(A_MASK, 32'h0);
    op(15'h0000, 32'h0, 16'h0004);
    mrd(1'h1, 15'h1000, 32'h1234_5678, 1'h0);
    chk({31'h0, o_irq}, 32'h0);
    $display("test protect done");
  endtask
  task automatic t_bitband;
    bbc(1'h1, 32'h2202_000C, 1'h1, 1'h0);
    chk(mem.sram[11'h400], 32'h8);
    bbc(1'h0, 32'h2202_000C, 1'h1, 1'h0);
    bbc(1'h0, 32'h2202_0008, 1'h0, 1'h0);
    bbc(1'h1, 32'h2204_0000, 1'h1, 1'h1);
    bbc(1'h1, 32'h2202_000C, 1'h0, 1'h0);
    chk(mem.sram[11'h400], 32'h0);
    $display("test bitband done");
  endtask
  task automatic t_commit;
    op(15'h0001, 32'h0, 16'h0008);
    repeat (2) @(posedge i_clock);
    chk({16'h0, i_nv_pe}, 32'hFFFD);
    chk({16'h0, i_nv_re}, 32'hFFFF);
    @(posedge i_clock);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'h0;
    repeat (2) @(posedge i_clock);
    rdc(A_PE, 32'hFFFF, 32'hFFFD, RESP_OK);
    rdc(A_RE, 32'hFFFF, 32'hFFFF, RESP_OK);
    $display("test commit done");
  endtask
  initial begin
    fails = 0;
    tests_run = 0;
    i_rst = 1'h1;
    i_wstrb = 4'hF;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_if_req, i_d_req} = 7'h0;
    {i_bb_req, i_bb_we, i_bb_wbit, i_awaddr, i_wdata, i_araddr, i_bb_addr} = '0;
    {i_if_addr, i_d_addr} = 30'h0;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'h0;
    repeat (2) @(posedge i_clock);
    t_regs;
    t_prog;
    t_protect;
    t_bitband;
    t_commit;
    stop_test;
  end
endmodule // tb_top
